// [ufd_pkg.sv]
// Shared constants for the UART format and data register block
`default_nettype none
package ufd_pkg;
  // Register byte offsets
  localparam logic [4:0] ADDR_STATUS  = 5'h04;
  localparam logic [4:0] ADDR_FORMAT  = 5'h08;
  localparam logic [4:0] ADDR_TXCHAR  = 5'h0C;
  localparam logic [4:0] ADDR_RXCHAR  = 5'h10;
  localparam logic [4:0] ADDR_IRQ_ST  = 5'h14;
  localparam logic [4:0] ADDR_IRQ_MSK = 5'h18;
  localparam logic [4:0] ADDR_BAUD    = 5'h1C;
  // Format register field positions
  localparam int FMT_BREAK  = 7;
  localparam int FMT_CHR7   = 6;
  localparam int FMT_STOP2  = 5;
  localparam int FMT_PAR_EN = 4;
  localparam int FMT_PAR_OD = 3;
  localparam logic [7:0] FMT_WR_MASK = 8'hF8;
  // Status register field positions
  localparam int ST_PERR = 3;
  localparam int ST_RBF  = 2;
  localparam int ST_TSBE = 1;
  localparam int ST_TBE  = 0;
  // Interrupt status bits: tx empty, rx full, parity error
  localparam int IRQ_TBE  = 0;
  localparam int IRQ_RBF  = 1;
  localparam int IRQ_PERR = 2;
  localparam int IRQ_W    = 3;
  // Reset values
  localparam logic [7:0]  FORMAT_RST = 8'h00;
  localparam logic [15:0] BAUD_RST   = 16'h0006;
  // Sixteen oversample ticks per bit
  localparam logic [3:0]  OVS_LAST = 4'hF;
  localparam logic [3:0]  OVS_MID  = 4'h7;
endpackage : ufd_pkg
`default_nettype wire

// [ufd_tx.sv]
// Serial transmit shifter with break and format control
`default_nettype none
module ufd_tx (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_tick,
  input  wire logic       i_load,
  input  wire logic [7:0] i_data,
  input  wire logic [7:0] i_format,
  output logic            o_busy,
  output logic            o_txd
);
  logic [10:0] shift;
  logic [3:0]  bits_left;
  logic [3:0]  ovs;
  logic        line;

  function automatic logic [10:0] ufd_frame(input logic [7:0] d, input logic [7:0] f);
    logic [7:0]  dm;
    logic        par;
    logic [10:0] fr;
    dm = f[ufd_pkg::FMT_CHR7] ? {1'b0, d[6:0]} : d;
    par = (^dm) ^ f[ufd_pkg::FMT_PAR_OD];
    fr = 11'h7FF;
    if (f[ufd_pkg::FMT_CHR7]) begin
      fr[7:0] = {dm[6:0], 1'b0};
      if (f[ufd_pkg::FMT_PAR_EN]) fr[8] = par;
    end else begin
      fr[8:0] = {dm, 1'b0};
      if (f[ufd_pkg::FMT_PAR_EN]) fr[9] = par;
    end
    return fr;
  endfunction : ufd_frame

  // Frame length: start, data, parity, stops
  function automatic logic [3:0] ufd_len(input logic [7:0] f);
    ufd_len = 4'd10 - {3'd0, f[ufd_pkg::FMT_CHR7]} + {3'd0, f[ufd_pkg::FMT_PAR_EN]}
              + {3'd0, f[ufd_pkg::FMT_STOP2]};
  endfunction : ufd_len

  // Shift out LSB first, one bit per sixteen ticks
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      shift     <= 11'h7FF;
      bits_left <= 4'd0;
      ovs       <= 4'd0;
      line      <= 1'b1;
    end else if (i_load && bits_left == 4'd0) begin
      shift     <= ufd_frame(i_data, i_format);
      bits_left <= ufd_len(i_format);
      ovs       <= 4'd0;
      line      <= 1'b0;
    end else if (bits_left != 4'd0 && i_tick) begin
      ovs <= ovs + 4'd1;
      if (ovs == ufd_pkg::OVS_LAST) begin
        shift     <= {1'b1, shift[10:1]};
        bits_left <= bits_left - 4'd1;
        line      <= (bits_left == 4'd1) ? 1'b1 : shift[1];
      end
    end
  end

  assign o_busy = (bits_left != 4'd0);
  // Break forces the line low while set, a frame in flight still runs underneath
  assign o_txd = line & ~i_format[ufd_pkg::FMT_BREAK];
endmodule : ufd_tx
`default_nettype wire

// [ufd_rx.sv]
// Serial receive shifter with parity and framing checks
`default_nettype none
module ufd_rx (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_tick,
  input  wire logic       i_rxd,
  input  wire logic [7:0] i_format,
  output logic            o_done,
  output logic [7:0]      o_data,
  output logic            o_perr,
  output logic            o_ferr
);
  typedef enum logic [1:0] {
    UFD_R_IDLE  = 2'b00,
    UFD_R_START = 2'b01,
    UFD_R_BITS  = 2'b10
  } ufd_rx_state_t;

  ufd_rx_state_t state;
  logic [2:0]    sync;
  logic          rxd_s;
  logic [3:0]    ovs;
  logic [3:0]    idx;
  logic [3:0]    nbits;
  logic [9:0]    buf_bits;
  logic [7:0]    dm;
  logic          par_ok;

  // Three stage synchroniser, the level changes once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync  <= 3'b111;
      rxd_s <= 1'b1;
    end else begin
      sync <= {sync[1:0], i_rxd};
      if (sync[1] == sync[2]) rxd_s <= sync[2];
    end
  end

  // Data bits plus parity, then one stop sample checked; second stop not sampled
  assign nbits = 4'd8 - {3'd0, i_format[ufd_pkg::FMT_CHR7]} + {3'd0, i_format[ufd_pkg::FMT_PAR_EN]};
  assign dm = i_format[ufd_pkg::FMT_CHR7] ? {1'b0, buf_bits[6:0]} : buf_bits[7:0];
  assign par_ok = ~i_format[ufd_pkg::FMT_PAR_EN] |
                  (((^dm) ^ i_format[ufd_pkg::FMT_PAR_OD]) ==
                   (i_format[ufd_pkg::FMT_CHR7] ? buf_bits[7] : buf_bits[8]));

  // Mid-bit sampling state machine
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state    <= UFD_R_IDLE;
      ovs      <= 4'd0;
      idx      <= 4'd0;
      buf_bits <= 10'h000;
      o_done   <= 1'b0;
      o_data   <= 8'h00;
      o_perr   <= 1'b0;
      o_ferr   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        UFD_R_IDLE: begin
          ovs <= 4'd0;
          idx <= 4'd0;
          if (!rxd_s) state <= UFD_R_START;
        end
        UFD_R_START: begin
          if (i_tick) begin
            ovs <= ovs + 4'd1;
            if (ovs == ufd_pkg::OVS_MID) begin
              ovs   <= 4'd0;
              state <= rxd_s ? UFD_R_IDLE : UFD_R_BITS; // Glitch rejected
            end
          end
        end
        UFD_R_BITS: begin
          if (i_tick) begin
            ovs <= ovs + 4'd1;
            if (ovs == ufd_pkg::OVS_LAST) begin
              if (idx == nbits) begin
                o_done <= 1'b1;
                o_data <= dm;
                o_perr <= ~par_ok;
                o_ferr <= ~rxd_s;
                state  <= UFD_R_IDLE;
              end else begin
                buf_bits[idx] <= rxd_s;
                idx <= idx + 4'd1;
              end
            end
          end
        end
        default: state <= UFD_R_IDLE;
      endcase
    end
  end
endmodule : ufd_rx
`default_nettype wire

// [ufd_top.sv]
// UART format control and data registers on a classic Wishbone slave
`default_nettype none
// How it works
// - Break bit holds transmit line low
// - Length bit picks eight or seven data bits
// - Stop bit picks one or two stops
// - Parity enable adds and checks parity
// - Parity sense picks even or odd
// - Reserved bits always read back zero
// - Transmit register takes character, queues it
// - Receive register shows last character, resets zero
// - Empty flag sets on move, clears on write
// - Full flag sets on store, clears on read
// - Parity error flag set, cleared by read
module ufd_top (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [4:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_irq,
  input  wire logic        i_rxd,
  output logic             o_txd
);
  logic [7:0]  uart_format_control;
  logic [7:0]  tx_character;
  logic [7:0]  uart_receive_character;
  logic [15:0] baud_div;
  logic [15:0] baud_cnt;
  logic        tick;
  logic        tx_buffer_empty_flag;
  logic        rx_buffer_full_flag;
  logic        parity_err;
  logic        frame_err;
  logic        overrun_err;
  logic        tx_busy;
  logic        tx_load;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_perr;
  logic        rx_ferr;
  logic [ufd_pkg::IRQ_W-1:0] irq_status;
  logic [ufd_pkg::IRQ_W-1:0] irq_mask;
  logic [ufd_pkg::IRQ_W-1:0] irq_event;
  logic        req;
  logic        wr;
  logic        rd;
  logic [31:0] next_rdata;

  // Single cycle request strobe; ack drops the cycle after it is given
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr  = req & i_wb_we;
  assign rd  = req & ~i_wb_we;

  function automatic logic ufd_hit(input logic [4:0] a, input logic [4:0] r);
    return a == r;
  endfunction : ufd_hit

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) o_wb_ack <= 1'b0;
    else o_wb_ack <= req;
  end

  // Format register; low byte lane only, reserved bits dropped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      uart_format_control <= ufd_pkg::FORMAT_RST;
    end else if (wr && i_wb_sel[0] && ufd_hit(i_wb_adr, ufd_pkg::ADDR_FORMAT)) begin
      uart_format_control <= i_wb_dat[7:0] & ufd_pkg::FMT_WR_MASK;
    end
  end

  // Bit rate divider, tick is sixteen times the bit rate
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      baud_div <= ufd_pkg::BAUD_RST;
    end else if (wr && ufd_hit(i_wb_adr, ufd_pkg::ADDR_BAUD)) begin
      if (i_wb_sel[0]) baud_div[7:0]  <= i_wb_dat[7:0];
      if (i_wb_sel[1]) baud_div[15:8] <= i_wb_dat[15:8];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (baud_cnt >= baud_div) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // Transmit holding register and its empty flag
  // A write while full overwrites the held character; software must avoid it
  assign tx_load = ~tx_buffer_empty_flag & ~tx_busy;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_character         <= 8'h00;
      tx_buffer_empty_flag <= 1'b1;
    end else if (wr && i_wb_sel[0] && ufd_hit(i_wb_adr, ufd_pkg::ADDR_TXCHAR)) begin
      tx_character         <= i_wb_dat[7:0];
      tx_buffer_empty_flag <= 1'b0;
    end else if (tx_load) begin
      tx_buffer_empty_flag <= 1'b1;
    end
  end

  ufd_tx u_tx (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_tick    (tick),
    .i_load    (tx_load),
    .i_data    (tx_character),
    .i_format  (uart_format_control),
    .o_busy    (tx_busy),
    .o_txd     (o_txd)
  );

  ufd_rx u_rx (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_tick    (tick),
    .i_rxd     (i_rxd),
    .i_format  (uart_format_control),
    .o_done    (rx_done),
    .o_data    (rx_data),
    .o_perr    (rx_perr),
    .o_ferr    (rx_ferr)
  );

  // Receive register and flags; a new character wins over a same-cycle read
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      uart_receive_character <= 8'h00;
      rx_buffer_full_flag    <= 1'b0;
      parity_err             <= 1'b0;
      frame_err              <= 1'b0;
      overrun_err            <= 1'b0;
    end else if (rx_done) begin
      uart_receive_character <= rx_data;
      rx_buffer_full_flag    <= 1'b1;
      parity_err             <= rx_perr;
      frame_err              <= rx_ferr;
      overrun_err            <= rx_buffer_full_flag;
    end else if (rd && ufd_hit(i_wb_adr, ufd_pkg::ADDR_RXCHAR)) begin
      rx_buffer_full_flag <= 1'b0;
      parity_err          <= 1'b0;
      frame_err           <= 1'b0;
      overrun_err         <= 1'b0;
    end
  end

  // Sticky interrupt status, set wins over write-one-to-clear
  assign irq_event[ufd_pkg::IRQ_TBE]  = tx_load;
  assign irq_event[ufd_pkg::IRQ_RBF]  = rx_done;
  assign irq_event[ufd_pkg::IRQ_PERR] = rx_done & rx_perr;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_status <= '0;
    end else if (wr && i_wb_sel[0] && ufd_hit(i_wb_adr, ufd_pkg::ADDR_IRQ_ST)) begin
      irq_status <= (irq_status & ~i_wb_dat[ufd_pkg::IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) irq_mask <= '0;
    else if (wr && i_wb_sel[0] && ufd_hit(i_wb_adr, ufd_pkg::ADDR_IRQ_MSK))
      irq_mask <= i_wb_dat[ufd_pkg::IRQ_W-1:0];
  end

  assign o_irq = |(irq_status & irq_mask);

  // Read mux; unused and reserved bits and unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_wb_adr)
      ufd_pkg::ADDR_STATUS: begin
        next_rdata[ufd_pkg::ST_PERR] = parity_err;
        next_rdata[ufd_pkg::ST_RBF]  = rx_buffer_full_flag;
        next_rdata[ufd_pkg::ST_TSBE] = ~tx_busy;
        next_rdata[ufd_pkg::ST_TBE]  = tx_buffer_empty_flag;
        next_rdata[5]                = frame_err;
        next_rdata[6]                = overrun_err;
      end
      ufd_pkg::ADDR_FORMAT:  next_rdata[7:0] = uart_format_control;
      ufd_pkg::ADDR_RXCHAR:  next_rdata[7:0] = uart_receive_character;
      ufd_pkg::ADDR_IRQ_ST:  next_rdata[ufd_pkg::IRQ_W-1:0] = irq_status;
      ufd_pkg::ADDR_IRQ_MSK: next_rdata[ufd_pkg::IRQ_W-1:0] = irq_mask;
      ufd_pkg::ADDR_BAUD:    next_rdata[15:0] = baud_div;
      default:               next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) o_wb_dat <= 32'h0000_0000;
    else if (rd) o_wb_dat <= next_rdata;
  end
endmodule : ufd_top
`default_nettype wire

// [ufd_props.sv]
// Concurrent checks on the ports of the UART format block
`default_nettype none
module ufd_props (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [4:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_irq,
  input wire logic        i_rxd,
  input wire logic        o_txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fmt;
  logic       rd;
  logic [4:0] ra;
  logic       fast;
  logic       take;
  logic       wtx;
  // Request taken on this edge
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wtx  = take && i_wb_we && i_wb_adr == ufd_pkg::ADDR_TXCHAR;
  // Shadow of format and divider; the start bound only holds at the fastest divider
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fmt  <= 8'h00;
      fast <= 1'b0;
    end else if (take && i_wb_we && i_wb_adr == ufd_pkg::ADDR_FORMAT) begin
      fmt <= i_wb_dat[7:0] & ufd_pkg::FMT_WR_MASK;
    end else if (take && i_wb_we && i_wb_adr == ufd_pkg::ADDR_BAUD) begin
      fast <= i_wb_dat[15:0] == 16'h0000;
    end
  end
  // Read in flight, answered on the next cycle
  always_ff @(posedge i_clk) begin
    rd <= take && !i_wb_we && !i_sys_rst;
    ra <= i_wb_adr;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_take; take; endsequence
  sequence s_ack_once; o_wb_ack ##1 !o_wb_ack; endsequence
  property p_ack; s_take |=> s_ack_once; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  property p_ack_cause; $rose(o_wb_ack) |-> $past(take); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rst_idle; $fell(i_sys_rst) |-> o_txd && !o_irq && !o_wb_ack; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_break; fmt[7] [*3] |-> !o_txd; endproperty
  a_break: assert property (p_break) else $error("line not low during break");
  property p_fmt_rd; rd && ra == ufd_pkg::ADDR_FORMAT |-> o_wb_dat == {24'h00_0000, fmt}; endproperty
  a_fmt_rd: assert property (p_fmt_rd) else $error("format readback wrong");
  property p_rx_rsv; rd && ra == ufd_pkg::ADDR_RXCHAR |-> o_wb_dat[31:8] == 24'h00_0000; endproperty
  a_rx_rsv: assert property (p_rx_rsv) else $error("receive upper bits not zero");
  property p_hold; $changed(o_wb_dat) |-> o_wb_ack; endproperty
  a_hold: assert property (p_hold) else $error("read data moved without ack");
  property p_start; wtx && fast && !fmt[7] |-> ##[1:600] !o_txd; endproperty
  a_start: assert property (p_start) else $error("no start bit after character write");
endmodule : ufd_props
bind ufd_top ufd_props i_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq), .i_rxd(i_rxd), .o_txd(o_txd));
`default_nettype wire

// [ufd_remote.sv]
// Remote serial device model on the transmit and receive lines
`default_nettype none
module ufd_remote #(
  parameter int BITC = 16
) (
  input  wire logic i_clk,
  input  wire logic i_txd,
  output var logic  o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned now  = 0;
  int unsigned last = 0;
  initial o_rxd = 1'b1;
  // Free cycle count, times the distance between start bits
  always @(posedge i_clk) now <= now + 1;
  // Sends one frame; flip spoils the parity on purpose
  task automatic send(input logic [7:0] d, input logic [7:0] f, input logic flip);
    o_rxd <= 1'b0;
    repeat (BITC) @(posedge i_clk);
    for (int i = 0; i < (f[6] ? 7 : 8); i++) begin
      o_rxd <= d[i];
      repeat (BITC) @(posedge i_clk);
    end
    if (f[4]) begin
      o_rxd <= ^(f[6] ? {1'b0, d[6:0]} : d) ^ f[3] ^ flip;
      repeat (BITC) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    repeat ((f[5] ? 2 : 1) * BITC) @(posedge i_clk);
  endtask : send
  // Takes one frame at bit centres; ends in the middle of the first stop
  task automatic get(input logic [7:0] f, output logic [7:0] d, output logic p, output int unsigned gap);
    int k;
    k = 0;
    while (i_txd !== 1'b0 && k < 2000) begin
      @(posedge i_clk);
      k++;
    end
    gap = (k < 2000) ? now - last : 0;
    last = now;
    d = 8'h00;
    p = 1'b1;
    repeat (BITC / 2) @(posedge i_clk);
    for (int i = 0; i < (f[6] ? 7 : 8); i++) begin
      repeat (BITC) @(posedge i_clk);
      d[i] = i_txd;
    end
    if (f[4]) begin
      repeat (BITC) @(posedge i_clk);
      p = i_txd;
    end
    repeat (BITC) @(posedge i_clk);
  endtask : get
endmodule : ufd_remote
`default_nettype wire

// [test_uart_format_and_data_regs.sv]
// Self-checking bench for the UART format and data register block
`default_nettype none
module test_uart_format_and_data_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] fmt; logic [7:0] tx; logic [7:0] rx;} ufd_row_t;
  // Format, sent character, character read back
  localparam ufd_row_t ROWS [5] = '{'{8'h00, 8'hA5, 8'hA5}, '{8'h40, 8'hC3, 8'h43},
    '{8'h20, 8'h5A, 8'h5A}, '{8'h10, 8'h96, 8'h96}, '{8'h18, 8'h3C, 8'h3C}};
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [4:0]  adr  = 5'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        irq;
  logic        rxd;
  logic        txd;
  logic [7:0]  d;
  logic        p;
  int unsigned g;
  int          num_errors = 0;
  int          n_checks = 0;
  always #4 clk = ~clk;
  ufd_top i_dut (.i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_irq(irq), .i_rxd(rxd), .o_txd(txd));
  ufd_remote i_remote (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  // One classic cycle, held until ack is sampled; the idle cycle after keeps strobes apart
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] v = 32'h0000_0000);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
    @(posedge clk);
  endtask : wb
  // Polls status until a flag is up, bounded
  task automatic wait_st(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, ufd_pkg::ADDR_STATUS);
      n++;
    end while (q[b] !== 1'b1 && n < 500);
    if (q[b] !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
  endtask : wait_st
  initial begin
    int e;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, ufd_pkg::ADDR_FORMAT);
    chk(q, 32'h0000_0000);
    wb(1'b0, ufd_pkg::ADDR_RXCHAR);
    chk(q, 32'h0000_0000);
    wb(1'b0, ufd_pkg::ADDR_STATUS);
    chk(q & 32'h0000_000F, 32'h0000_0003);
    wb(1'b0, 5'h00);
    chk(q, 32'h0000_0000);
    $display("Test reset values done");
    wb(1'b1, ufd_pkg::ADDR_BAUD, 32'h0000_0000);
    wb(1'b1, ufd_pkg::ADDR_IRQ_MSK, 32'h0000_0002);
    // Two back-to-back characters out, one in, per format
    foreach (ROWS[r]) begin
      wb(1'b1, ufd_pkg::ADDR_FORMAT, 32'(ROWS[r].fmt));
      wb(1'b0, ufd_pkg::ADDR_FORMAT);
      chk(q, 32'(ROWS[r].fmt));
      fork
        begin
          i_remote.get(ROWS[r].fmt, d, p, g);
          i_remote.get(ROWS[r].fmt, d, p, g);
        end
      join_none
      wb(1'b1, ufd_pkg::ADDR_TXCHAR, 32'(ROWS[r].tx));
      wait_st(ufd_pkg::ST_TBE);
      wb(1'b1, ufd_pkg::ADDR_TXCHAR, 32'(ROWS[r].tx));
      // Second character waits behind a busy shifter, so both empty flags read low
      wb(1'b0, ufd_pkg::ADDR_STATUS);
      chk(q & 32'h0000_0003, 32'h0000_0000);
      wait fork;
      chk(32'(d), 32'(ROWS[r].rx));
      if (ROWS[r].fmt[4]) chk(32'(p), 32'(^ROWS[r].rx ^ ROWS[r].fmt[3]));
      e = 16 * (2 + (ROWS[r].fmt[6] ? 7 : 8) + ROWS[r].fmt[4] + ROWS[r].fmt[5]);
      chk(32'(g >= e && g <= e + 20), 32'h0000_0001);
      i_remote.send(ROWS[r].tx, ROWS[r].fmt, 1'b0);
      wait_st(ufd_pkg::ST_RBF);
      wb(1'b0, ufd_pkg::ADDR_RXCHAR);
      chk(q, 32'(ROWS[r].rx));
      wb(1'b0, ufd_pkg::ADDR_STATUS);
      chk(q & 32'h0000_000C, 32'h0000_0000);
      $display("Test format row %0d done", r);
    end
    // Spoiled parity, then the interrupt masked, unmasked and cleared
    wb(1'b1, ufd_pkg::ADDR_IRQ_ST, 32'h0000_0007);
    chk(32'(irq), 32'h0000_0000);
    wb(1'b1, ufd_pkg::ADDR_FORMAT, 32'h0000_0010);
    i_remote.send(8'h31, 8'h10, 1'b1);
    wait_st(ufd_pkg::ST_RBF);
    chk(q & 32'h0000_0008, 32'h0000_0008);
    chk(32'(irq), 32'h0000_0001);
    wb(1'b0, ufd_pkg::ADDR_IRQ_ST);
    chk(q, 32'h0000_0006);
    wb(1'b1, ufd_pkg::ADDR_IRQ_MSK, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wb(1'b1, ufd_pkg::ADDR_IRQ_MSK, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    wb(1'b1, ufd_pkg::ADDR_IRQ_ST, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000);
    wb(1'b0, ufd_pkg::ADDR_RXCHAR);
    chk(q, 32'h0000_0031);
    wb(1'b0, ufd_pkg::ADDR_STATUS);
    chk(q & 32'h0000_000C, 32'h0000_0000);
    $display("Test parity error and interrupt done");
    wb(1'b1, ufd_pkg::ADDR_FORMAT, 32'h0000_0080);
    repeat (8) @(posedge clk);
    chk(32'(txd), 32'h0000_0000);
    wb(1'b1, ufd_pkg::ADDR_FORMAT, 32'h0000_0000);
    repeat (8) @(posedge clk);
    chk(32'(txd), 32'h0000_0001);
    $display("Test break done");
    // Leave a non-zero format behind so the reset has something to undo
    wb(1'b1, ufd_pkg::ADDR_FORMAT, 32'h0000_0038);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, ufd_pkg::ADDR_FORMAT);
    chk(q, 32'h0000_0000);
    wb(1'b0, ufd_pkg::ADDR_STATUS);
    chk(q & 32'h0000_000F, 32'h0000_0003);
    chk(32'(irq), 32'h0000_0000);
    $display("Test second reset done");
    print_verdict();
  end
endmodule : test_uart_format_and_data_regs
`default_nettype wire
